// ### hdl/cpu_interrupt_reset_control.sv
// Interrupt, exception and reset sequencer with AHB-Lite register access
`timescale 1ns/100ps
module cpu_interrupt_reset_control #(
    parameter int RST_DELAY = irc_pkg::RST_DLY_CYC
) (
    input  wire logic              hclk,            // Clock
    input  wire logic              hresetn,         // Async reset, active low
    input  wire logic              hsel,            // AHB select
    input  wire logic [31:0]       haddr,           // AHB address
    input  wire logic [1:0]        htrans,          // AHB transfer type
    input  wire logic              hwrite,          // AHB write
    input  wire logic [2:0]        hsize,           // AHB size
    input  wire logic [31:0]       hwdata,          // AHB write data
    input  wire logic              hready,          // AHB ready in
    output logic                   hreadyout,       // AHB ready out
    output logic [31:0]            hrdata,          // AHB read data
    output logic                   hresp,           // AHB response
    input  wire logic              cpu_reset_in,    // Reset pin, active high
    input  wire logic              nmi_in,          // Non-maskable request pin
    input  wire logic              maskable_irq_in, // Maskable request pin
    input  wire logic              coproc_err_in,   // Coprocessor error pin
    input  wire irc_pkg::core_evt_t evt,            // Instruction boundary event
    input  wire logic              cpso_evt,        // Coprocessor segment overrun pulse
    input  wire irc_pkg::io_req_t  io_req,          // Port address request
    output logic                   inta_req,        // Acknowledge sequence request
    input  wire logic              inta_ack,        // Acknowledge complete
    input  wire logic [7:0]        inta_vec,        // Vector from controller
    output logic                   push_valid,      // Stack push request
    output logic [15:0]            push_data,       // Word to push
    input  wire logic              push_ready,      // Push accepted
    output logic                   tbl_req,         // Table read request
    output logic [9:0]             tbl_addr,        // Table byte address
    input  wire logic              tbl_ack,         // Table read done
    input  wire logic [31:0]       tbl_data,        // Segment and offset
    output logic                   run_ok,          // Core may execute
    output logic                   bus_en,          // Core may use the bus
    output logic [23:0]            fetch_addr,      // Next fetch address
    output logic [15:0]            io_addr          // Formed port address
);
    typedef enum logic [3:0] {
        S_RESET, S_INIT, S_RUN, S_HALT, S_CHECK, S_ACK, S_PUSHF, S_PUSHC, S_PUSHI, S_TBL
    } phase_t;

    typedef struct packed {
        phase_t      phase;
        logic [15:0] cnt;
        logic [15:0] flags;
        logic [15:0] machine_state_word;
        logic [15:0] ip;
        logic [15:0] cs;
        logic [15:0] ds;
        logic [15:0] es;
        logic [15:0] ss;
        logic [15:0] port;
        logic [3:0]  hi_nib;
        logic [7:0]  vec;
        logic [7:0]  last_vec;
        logic        exc_pend;
        logic [7:0]  exc_vec;
        logic        step_pend;
        logic        int_pend;
        logic [7:0]  int_vec;
        logic        nmi_pend;
        logic        nmi_active;
        logic        nmi_prev;
        logic        so_pend;
        logic [15:0] push_data;
        logic [9:0]  tbl_addr;
        logic [15:0] io_addr;
        logic [23:0] fetch;
        logic        dp_wr;
        logic [7:0]  dp_addr;
        logic [31:0] rdata;
    } st_t;

    st_t        r;
    st_t        n;
    logic [3:0] pins_s;
    logic       rst_s;
    logic       nmi_s;
    logic       irq_s;
    logic       cperr_s;

    generate
        if (RST_DELAY < 1 || RST_DELAY > 65535) begin : g_chk
            $error("RST_DELAY must lie in 1..65535");
        end
    endgenerate

    sync_two #(
        .W (4)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({cpu_reset_in, nmi_in, maskable_irq_in, coproc_err_in}),
        .q       (pins_s)
    );
    assign {rst_s, nmi_s, irq_s, cperr_s} = pins_s;

    // Writable registers
    function automatic logic is_rw(input logic [7:0] a);
        is_rw = (a == irc_pkg::OFF_FLAGS) || (a == irc_pkg::OFF_MSW) ||
                (a == irc_pkg::OFF_IP)    || (a == irc_pkg::OFF_CS)  ||
                (a == irc_pkg::OFF_DS)    || (a == irc_pkg::OFF_ES)  ||
                (a == irc_pkg::OFF_SS)    || (a == irc_pkg::OFF_PORT);
    endfunction : is_rw

    function automatic logic [31:0] rd_mux(input st_t s, input logic [7:0] a);
        case (a)
            irc_pkg::OFF_FLAGS:  rd_mux = {16'h0000, s.flags};
            irc_pkg::OFF_MSW:    rd_mux = {16'h0000, s.machine_state_word};
            irc_pkg::OFF_IP:     rd_mux = {16'h0000, s.ip};
            irc_pkg::OFF_CS:     rd_mux = {16'h0000, s.cs};
            irc_pkg::OFF_DS:     rd_mux = {16'h0000, s.ds};
            irc_pkg::OFF_ES:     rd_mux = {16'h0000, s.es};
            irc_pkg::OFF_SS:     rd_mux = {16'h0000, s.ss};
            irc_pkg::OFF_PORT:   rd_mux = {16'h0000, s.port};
            irc_pkg::OFF_STATUS: rd_mux = {8'h00, s.last_vec, 6'h00, s.so_pend, s.int_pend,
                                           s.exc_pend, s.step_pend, s.nmi_pend, s.nmi_active,
                                           4'(s.phase)};
            irc_pkg::OFF_IOADDR: rd_mux = {16'h0000, s.io_addr};
            irc_pkg::OFF_FETCH:  rd_mux = {8'h00, s.fetch};
            default:             rd_mux = 32'h0000_0000;
        endcase
    endfunction : rd_mux

    // Pin reset state; bus-side fields are kept
    function automatic st_t apply_reset(input st_t s);
        st_t t;
        t            = s;
        t.phase      = S_RESET;
        t.cnt        = 16'h0000;
        t.flags      = irc_pkg::FLAGS_RST;
        t.machine_state_word        = irc_pkg::MSW_RST;
        t.ip         = irc_pkg::IP_RST;
        t.cs         = irc_pkg::CS_RST;
        t.ds         = irc_pkg::SEG_RST;
        t.es         = irc_pkg::SEG_RST;
        t.ss         = irc_pkg::SEG_RST;
        t.hi_nib     = irc_pkg::HI_NIB_RST;
        t.exc_pend   = 1'b0;
        t.step_pend  = 1'b0;
        t.int_pend   = 1'b0;
        t.nmi_pend   = 1'b0;
        t.nmi_active = 1'b0;
        t.so_pend    = 1'b0;
        t.fetch      = {irc_pkg::HI_NIB_RST, 20'({irc_pkg::CS_RST, 4'h0} +
                        {4'h0, irc_pkg::IP_RST})};
        return t;
    endfunction : apply_reset

    always_comb begin
        logic        hw_ok;
        logic        nmi_rise;
        logic        enter;
        logic        fault;
        logic [7:0]  fvec;
        n        = r;
        hw_ok    = !r.nmi_active;
        nmi_rise = nmi_s && !r.nmi_prev;
        enter    = 1'b0;
        fault    = 1'b0;
        fvec     = irc_pkg::VEC_DIV;
        n.nmi_prev = nmi_s;

        // Read data captured here so it leaves a flop
        n.dp_wr = 1'b0;
        if (hsel && htrans[1] && hready) begin
            n.dp_wr   = hwrite;
            n.dp_addr = haddr[7:0];
            if (!hwrite) begin
                // Forward a pending write, else the read is stale
                if (r.dp_wr && r.dp_addr == haddr[7:0] && is_rw(haddr[7:0])) begin
                    n.rdata = {16'h0000, hwdata[15:0]};
                end else begin
                    n.rdata = rd_mux(r, haddr[7:0]);
                end
            end
        end
        if (r.dp_wr) begin
            case (r.dp_addr)
                irc_pkg::OFF_FLAGS: n.flags = hwdata[15:0];
                irc_pkg::OFF_MSW:   n.machine_state_word   = hwdata[15:0];
                irc_pkg::OFF_IP:    n.ip    = hwdata[15:0];
                irc_pkg::OFF_CS:    n.cs    = hwdata[15:0];
                irc_pkg::OFF_DS:    n.ds    = hwdata[15:0];
                irc_pkg::OFF_ES:    n.es    = hwdata[15:0];
                irc_pkg::OFF_SS:    n.ss    = hwdata[15:0];
                irc_pkg::OFF_PORT:  n.port  = hwdata[15:0];
                default: ;
            endcase
        end

        if (io_req.valid && r.phase == S_RUN) begin
            n.io_addr = io_req.use_reg ? r.port : {8'h00, io_req.imm};
        end

        unique case (r.phase)
            S_RESET: begin
                n.phase = S_INIT;
            end
            S_INIT: begin
                n.cnt = r.cnt + 16'h0001;
                if (r.cnt == 16'(RST_DELAY - 1)) begin
                    n.phase = S_RUN;
                end
            end
            S_RUN: begin
                if (evt.valid) begin
                    n.ip = evt.next_ip;
                    case (evt.kind)
                        irc_pkg::EV_DIV: begin
                            fault = 1'b1;
                            fvec  = irc_pkg::VEC_DIV;
                        end
                        irc_pkg::EV_BADOP: begin
                            fault = 1'b1;
                            fvec  = irc_pkg::VEC_BADOP;
                        end
                        irc_pkg::EV_ESC: begin
                            if (r.machine_state_word[irc_pkg::MSW_EM] || r.machine_state_word[irc_pkg::MSW_TS]) begin
                                fault = 1'b1;
                                fvec  = irc_pkg::VEC_CPNA;
                            end else if (cperr_s) begin
                                fault = 1'b1;
                                fvec  = irc_pkg::VEC_CPERR;
                            end
                        end
                        irc_pkg::EV_WAIT: begin
                            if (r.machine_state_word[irc_pkg::MSW_MP] && r.machine_state_word[irc_pkg::MSW_TS]) begin
                                fault = 1'b1;
                                fvec  = irc_pkg::VEC_CPNA;
                            end else if (cperr_s) begin
                                fault = 1'b1;
                                fvec  = irc_pkg::VEC_CPERR;
                            end
                        end
                        irc_pkg::EV_INTO: begin
                            // Trap after completion; pointer stays past it
                            n.exc_pend = 1'b1;
                            n.exc_vec  = irc_pkg::VEC_INTO;
                        end
                        irc_pkg::EV_INT: begin
                            n.int_pend = 1'b1;
                            n.int_vec  = evt.vec;
                        end
                        irc_pkg::EV_INTERRUPT_RETURN: begin
                            n.flags      = evt.pop_flags;
                            n.cs         = evt.pop_cs;
                            n.nmi_active = 1'b0;
                        end
                        default: ;
                    endcase
                    if (fault) begin
                        n.exc_pend = 1'b1;
                        n.exc_vec  = fvec;
                        n.ip       = evt.cur_ip;
                    end
                    // Trap flag as it stood before the instruction
                    n.step_pend = r.step_pend || (r.flags[irc_pkg::FLAG_TF] && !fault);
                    if (evt.kind == irc_pkg::EV_HALT && !n.step_pend) begin
                        n.phase = S_HALT;
                    end else begin
                        n.phase = S_CHECK;
                    end
                end
            end
            S_HALT: begin
                if ((r.nmi_pend && hw_ok) || (irq_s && r.flags[irc_pkg::FLAG_IF] && hw_ok)) begin
                    n.phase = S_CHECK;
                end
            end
            S_CHECK: begin
                enter = 1'b1;
                if (r.exc_pend) begin
                    n.vec      = r.exc_vec;
                    n.exc_pend = 1'b0;
                end else if (r.step_pend) begin
                    n.vec       = irc_pkg::VEC_STEP;
                    n.step_pend = 1'b0;
                end else if (r.nmi_pend && hw_ok) begin
                    n.vec        = irc_pkg::VEC_NMI;
                    n.nmi_pend   = 1'b0;
                    n.nmi_active = 1'b1;
                end else if (r.so_pend && hw_ok) begin
                    n.vec     = irc_pkg::VEC_CPSO;
                    n.so_pend = 1'b0;
                end else if (irq_s && r.flags[irc_pkg::FLAG_IF] && hw_ok) begin
                    enter   = 1'b0;
                    n.phase = S_ACK;
                end else if (r.int_pend) begin
                    n.vec      = r.int_vec;
                    n.int_pend = 1'b0;
                end else begin
                    enter   = 1'b0;
                    n.phase = S_RUN;
                end
            end
            S_ACK: begin
                if (inta_ack) begin
                    n.vec = inta_vec;
                    enter = 1'b1;
                end
            end
            S_PUSHF: begin
                if (push_ready) begin
                    n.push_data = r.cs;
                    n.phase     = S_PUSHC;
                end
            end
            S_PUSHC: begin
                if (push_ready) begin
                    n.push_data = r.ip;
                    n.phase     = S_PUSHI;
                end
            end
            S_PUSHI: begin
                if (push_ready) begin
                    n.tbl_addr = {r.vec, 2'b00};
                    n.phase    = S_TBL;
                end
            end
            S_TBL: begin
                if (tbl_ack) begin
                    n.ip       = tbl_data[15:0];
                    n.cs       = tbl_data[31:16];
                    n.hi_nib   = 4'h0;
                    n.last_vec = r.vec;
                    // Recheck so nested requests enter first
                    n.phase    = S_CHECK;
                end
            end
        endcase

        if (enter) begin
            n.push_data = r.flags;
            n.flags[irc_pkg::FLAG_IF] = 1'b0;
            n.flags[irc_pkg::FLAG_TF] = 1'b0;
            n.phase = S_PUSHF;
        end

        // Sets after clears, so sets win
        if (nmi_rise) begin
            n.nmi_pend = 1'b1;
        end
        if (cpso_evt) begin
            n.so_pend = 1'b1;
        end

        if (rst_s) begin
            n = apply_reset(n);
        end
        n.fetch = {n.hi_nib, 20'({n.cs, 4'h0} + {4'h0, n.ip})};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= apply_reset('0);
        end else begin
            r <= n;
        end
    end

    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = r.rdata;
    assign inta_req   = (r.phase == S_ACK);
    assign push_valid = (r.phase == S_PUSHF) || (r.phase == S_PUSHC) || (r.phase == S_PUSHI);
    assign push_data  = r.push_data;
    assign tbl_req    = (r.phase == S_TBL);
    assign tbl_addr   = r.tbl_addr;
    assign run_ok     = (r.phase == S_RUN);
    assign bus_en     = (r.phase != S_RESET) && (r.phase != S_INIT) && (r.phase != S_HALT);
    assign fetch_addr = r.fetch;
    assign io_addr    = r.io_addr;
endmodule : cpu_interrupt_reset_control

// ### hdl/irc_pkg.sv
// Constants, carrier types and rule overview for the interrupt and reset block
// Overview of operation
// - Divide error takes vector 0, bad opcode 6, coprocessor absent 7.
// - Overflow trap takes vector 4; return address is past the instruction.
// - Coprocessor error raises vector 16 on coprocessor or wait instruction.
// - Exception returns to the faulting instruction and its prefixes.
// - Entry pushes flags, code segment, pointer; loads handler from table.
// - Table holds 256 handlers indexed by 8-bit vector; software reaches all.
// - Vectors 0 to 31 reserved for the core; 32 to 255 user.
// - Maskable request needs the enable flag; controller returns 8-bit vector.
// - Entry clears enable flag after saving flags; return restores saved flags.
// - Non-maskable request beats maskable, uses vector 2, no acknowledge sequence.
// - NMI handler blocks NMI, maskable and segment overrun until return.
// - NMI during NMI service is latched until the next return.
// - Trap flag set: vector 1 after next instruction; entry clears the flag.
// - Priority: exception, step, NMI, segment overrun, maskable, software interrupt.
// - Further enabled requests enter before the handler's first instruction.
// - Reset input high stops all execution and bus activity.
// - After reset and a delay, execution starts at physical FFFFF0.
// - Reset loads flags 0002, state word and pointer FFF0, code F000, others 0000; the port register keeps its value on pin reset.
// - Port address is zero-extended 8-bit immediate or 16-bit port register.
// - Halt resumes on NMI, enabled maskable request or reset; saves next address.
package irc_pkg;
    localparam logic [7:0]  VEC_DIV     = 8'h00;
    localparam logic [7:0]  VEC_STEP    = 8'h01;
    localparam logic [7:0]  VEC_NMI     = 8'h02;
    localparam logic [7:0]  VEC_INTO    = 8'h04;
    localparam logic [7:0]  VEC_BADOP   = 8'h06;
    localparam logic [7:0]  VEC_CPNA    = 8'h07;
    localparam logic [7:0]  VEC_CPSO    = 8'h09;
    localparam logic [7:0]  VEC_CPERR   = 8'h10;
    localparam logic [7:0]  VEC_USER_LO = 8'h20;
    localparam logic [15:0] FLAGS_RST   = 16'h0002;
    localparam logic [15:0] MSW_RST     = 16'hFFF0;
    localparam logic [15:0] IP_RST      = 16'hFFF0;
    localparam logic [15:0] CS_RST      = 16'hF000;
    localparam logic [15:0] SEG_RST     = 16'h0000;
    localparam logic [3:0]  HI_NIB_RST  = 4'hF;
    localparam int          FLAG_TF     = 8;
    localparam int          FLAG_IF     = 9;
    localparam int          MSW_MP      = 1;
    localparam int          MSW_EM      = 2;
    localparam int          MSW_TS      = 3;
    localparam int          CLK_MHZ     = 200;
    localparam int          RST_DLY_NS  = 250;
    localparam int          RST_DLY_CYC = (RST_DLY_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  OFF_FLAGS   = 8'h00;
    localparam logic [7:0]  OFF_MSW     = 8'h04;
    localparam logic [7:0]  OFF_IP      = 8'h08;
    localparam logic [7:0]  OFF_CS      = 8'h0C;
    localparam logic [7:0]  OFF_DS      = 8'h10;
    localparam logic [7:0]  OFF_ES      = 8'h14;
    localparam logic [7:0]  OFF_SS      = 8'h18;
    localparam logic [7:0]  OFF_PORT    = 8'h1C;
    localparam logic [7:0]  OFF_STATUS  = 8'h20;
    localparam logic [7:0]  OFF_IOADDR  = 8'h24;
    localparam logic [7:0]  OFF_FETCH   = 8'h28;

    typedef enum logic [3:0] {
        EV_NORMAL, EV_DIV, EV_BADOP, EV_ESC, EV_WAIT, EV_INTO, EV_INT, EV_INTERRUPT_RETURN, EV_HALT
    } ev_kind_t;

    typedef struct packed {
        logic        valid;
        ev_kind_t    kind;
        logic [7:0]  vec;
        logic [15:0] cur_ip;
        logic [15:0] next_ip;
        logic [15:0] pop_cs;
        logic [15:0] pop_flags;
    } core_evt_t;

    typedef struct packed {
        logic        valid;
        logic        use_reg;
        logic [7:0]  imm;
    } io_req_t;
endpackage : irc_pkg

// ### hdl/sync_two.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module sync_two #(
    parameter int W = 1
) (
    input  wire logic         hclk,    // Clock
    input  wire logic         hresetn, // Async reset, active low
    input  wire logic [W-1:0] d,       // Pin levels
    output logic      [W-1:0] q        // Synchronised levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_st_t;

    sync_st_t r;
    sync_st_t n;

    generate
        if (W < 1) begin : g_chk
            $error("sync_two width must be at least one");
        end
    endgenerate

    always_comb begin
        n    = r;
        n.s1 = d;
        n.s2 = r.s1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign q = r.s2;
endmodule : sync_two

// ### tb/cpu_interrupt_reset_control_tb_top.sv
// Self-checking bench for the interrupt and reset control block
`timescale 1ns/100ps
module cpu_interrupt_reset_control_tb_top;
    logic        hclk, hresetn, hsel, hwrite, cpu_reset_in, nmi_in, maskable_irq_in, slow;
    logic        hreadyout, hresp, inta_req, inta_ack, push_valid, push_ready;
    logic        tbl_req, tbl_ack, run_ok, bus_en;
    logic [1:0]  htrans;
    logic [7:0]  inta_vec;
    logic [9:0]  tbl_addr;
    logic [15:0] push_data, io_addr, last_push;
    logic [23:0] fetch_addr;
    logic [31:0] haddr, hwdata, hrdata, tbl_data, rd;
    logic [15:0] rv [7] = '{16'h0002, 16'hFFF0, 16'hFFF0, 16'hF000, 16'h0, 16'h0, 16'h0};
    logic [7:0]  vs [4] = '{8'h00, 8'h06, 8'h04, 8'h10};
    irc_pkg::ev_kind_t  ks [4] = '{irc_pkg::EV_DIV, irc_pkg::EV_BADOP, irc_pkg::EV_INTO,
                                   irc_pkg::EV_ESC};
    irc_pkg::core_evt_t evt;
    irc_pkg::io_req_t   io_req;
    int          n_errors = 0, checks = 0;
    cpu_interrupt_reset_control #(.RST_DELAY(2)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
        .cpu_reset_in, .nmi_in, .maskable_irq_in, .coproc_err_in(slow), .evt, .cpso_evt(1'b0),
        .io_req, .inta_req, .inta_ack, .inta_vec, .push_valid, .push_data, .push_ready,
        .tbl_req, .tbl_addr, .tbl_ack, .tbl_data, .run_ok, .bus_en, .fetch_addr, .io_addr);
    irc_partner far (.hclk, .hresetn, .slow, .inta_req, .inta_ack, .inta_vec, .push_valid,
        .push_ready, .tbl_req, .tbl_addr, .tbl_ack, .tbl_data);
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    always @(posedge hclk) if (push_valid && push_ready) last_push <= push_data;
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task print_verdict;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    task automatic wait_hi(ref logic s);
        int n = 0;
        do @(posedge hclk) #1; while (s !== 1'b1 && ++n < 300);
        if (s !== 1'b1) n_errors++;
        if (s !== 1'b1) print_verdict;
    endtask : wait_hi
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        wait_hi(hreadyout);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_hi(hreadyout);
        rd = hrdata;
    endtask : ahb
    task automatic step(input irc_pkg::ev_kind_t k);
        repeat (3) @(posedge hclk);
        evt <= '{1'b1, k, 8'h00, 16'h0100, 16'h0102, 16'h0000, 16'h0000};
        @(posedge hclk);
        evt.valid <= 1'b0;
        wait_hi(run_ok);
    endtask : step
    initial begin
        {hresetn, hwrite, cpu_reset_in, nmi_in, maskable_irq_in, slow} = '0;
        {htrans, haddr, hwdata, evt, io_req} = '0;
        hsel = 1'b1;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        wait_hi(run_ok);
        ahb(1'b1, irc_pkg::OFF_PORT, 32'h0000_1234);
        for (int u = 0; u < 2; u++) begin
            @(posedge hclk);
            io_req <= '{1'b1, u[0], 8'hC3};
            @(posedge hclk);
            io_req.valid <= 1'b0;
            #1 chk("io", u ? 32'h0000_1234 : 32'h0000_00C3, {16'h0, io_addr});
        end
        ahb(1'b1, irc_pkg::OFF_FLAGS, 32'h0000_0202);
        maskable_irq_in <= 1'b1;
        step(irc_pkg::EV_NORMAL);
        maskable_irq_in <= 1'b0;
        chk("fetch", 32'h0002_0100, {8'h0, fetch_addr});
        ahb(1'b0, irc_pkg::OFF_FLAGS, 32'h0);
        chk("flags", 32'h0000_0002, rd);
        $display("entry test done");
        slow <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            step(ks[i]);
            chk("fetch", 32'h0002_0000 + 32'(vs[i]) * 4, {8'h0, fetch_addr});
            chk("ret", i == 2 ? 32'h0102 : 32'h0100, {16'h0, last_push});
        end
        slow <= 1'b0;
        ahb(1'b1, irc_pkg::OFF_FLAGS, 32'h0000_0202);
        {nmi_in, maskable_irq_in} <= 2'h3;
        step(irc_pkg::EV_NORMAL);
        chk("fetch", 32'h0002_0008, {8'h0, fetch_addr});
        ahb(1'b1, irc_pkg::OFF_FLAGS, 32'h0000_0202);
        step(irc_pkg::EV_NORMAL);
        chk("fetch", 32'h0002_0102, {8'h0, fetch_addr});
        $display("exception test done");
        for (int i = 1; i < 7; i++) ahb(1'b1, 8'(i * 4), 32'h0000_5A5A);
        {nmi_in, maskable_irq_in, cpu_reset_in} <= 3'h1;
        repeat (6) @(posedge hclk);
        cpu_reset_in <= 1'b0;
        wait_hi(run_ok);
        chk("fetch", 32'h00FF_FFF0, {8'h0, fetch_addr});
        for (int i = 0; i < 7; i++) begin
            ahb(1'b0, 8'(i * 4), 32'h0);
            chk("reg", {16'h0, rv[i]}, rd);
        end
        ahb(1'b0, 8'h80, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("reset test done");
        print_verdict;
    end
endmodule : cpu_interrupt_reset_control_tb_top

// ### tb/irc_assertions.sv
// Port checker for the interrupt and reset control block
`timescale 1ns/100ps
module irc_assertions (
    input wire logic        hclk,         // Clock
    input wire logic        hresetn,      // Reset
    input wire logic        cpu_reset_in, // Core reset
    input wire logic        run_ok,       // Running
    input wire logic        bus_en,       // Bus use
    input wire logic [23:0] fetch_addr,   // Fetch
    input wire logic        inta_req,     // Ack request
    input wire logic        inta_ack,     // Ack done
    input wire logic        push_valid,   // Push
    input wire logic        push_ready,   // Push taken
    input wire logic [15:0] push_data,    // Push word
    input wire logic        tbl_req,      // Table read
    input wire logic [9:0]  tbl_addr      // Table address
);
    default clocking @(posedge hclk); endclocking
    // Entries abort under core reset
    default disable iff (!hresetn || cpu_reset_in);
    a_reset_halts: assert property (disable iff (!hresetn)
        cpu_reset_in [*4] |=> !run_ok && !bus_en) else $error("busy in reset");
    a_reset_fetch: assert property (disable iff (!hresetn)
        cpu_reset_in [*4] |=> fetch_addr == 24'hFF_FFF0) else $error("bad start");
    a_run_bus: assert property (run_ok |-> bus_en)
        else $error("run without bus");
    a_tbl_align: assert property (tbl_req |-> tbl_addr[1:0] == 2'h0)
        else $error("table index");
    a_entry_stall: assert property (push_valid || tbl_req || inta_req |-> !run_ok)
        else $error("run in entry");
    a_ack_flags: assert property (inta_req && inta_ack |=> push_valid && push_data[9])
        else $error("flags push");
    a_push_hold: assert property (push_valid && !push_ready |=>
        push_valid && $stable(push_data)) else $error("push dropped");
    a_one_req: assert property (inta_req |-> !push_valid && !tbl_req)
        else $error("overlap");
    c_mask: cover property (inta_req && inta_ack);
    c_push: cover property (push_valid && push_ready);
    c_reset: cover property (cpu_reset_in [*4]);
endmodule : irc_assertions
bind cpu_interrupt_reset_control irc_assertions chk (.*);

// ### tb/irc_partner.sv
// Controller and memory model on the far side
`timescale 1ns/100ps
module irc_partner (
    input  wire logic        hclk,       // Clock
    input  wire logic        hresetn,    // Reset
    input  wire logic        slow,       // Answer late
    input  wire logic        inta_req,   // Ack request
    output logic             inta_ack,   // Ack pulse
    output logic      [7:0]  inta_vec,   // Vector
    input  wire logic        push_valid, // Push
    output logic             push_ready, // Push taken
    input  wire logic        tbl_req,    // Table read
    input  wire logic [9:0]  tbl_addr,   // Table address
    output logic             tbl_ack,    // Read done
    output logic      [31:0] tbl_data    // Segment, offset
);
    logic [1:0] cnt_r;
    wire        go = !slow || cnt_r == 2'h3;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {cnt_r, inta_ack, push_ready, tbl_ack, inta_vec, tbl_data} <= '0;
        end else begin
            cnt_r      <= cnt_r + 2'h1;
            inta_ack   <= inta_req && go && !inta_ack;
            // Released data inverts
            inta_vec   <= (inta_req && go) ? 8'h40 : ~inta_vec;
            push_ready <= push_valid && go && !push_ready;
            tbl_ack    <= tbl_req && go && !tbl_ack;
            tbl_data   <= (tbl_req && go) ? {16'h2000, 6'h00, tbl_addr} : ~tbl_data;
        end
    end
endmodule : irc_partner
